// ### gpio_port_pkg.sv
// Package with register offsets, field positions, reset values and types of the GPIO port bank.
package gpio_port_pkg;
    localparam int PIN_COUNT = 8;
    localparam int ADDR_WIDTH = 6;
    localparam logic [5:0] OFS_GLOBAL_INPUT_ENABLE = 6'h00;
    localparam logic [5:0] OFS_OUTPUT_LATCH = 6'h04;
    localparam logic [5:0] OFS_PIN_DIRECTION = 6'h08;
    localparam logic [5:0] OFS_PIN_DIRECT_READ = 6'h0C;
    localparam logic [5:0] OFS_INPUT_LEVEL_SELECT = 6'h10;
    localparam logic [5:0] OFS_INPUT_LEVEL_SELECT_EXT = 6'h14;
    localparam logic [5:0] OFS_OUTPUT_DRIVE_SELECT = 6'h18;
    localparam logic [5:0] OFS_PULL_ENABLE = 6'h1C;
    localparam logic [5:0] OFS_PULL_SELECT = 6'h20;
    localparam logic [5:0] OFS_FUNCTION_SELECT = 6'h24;
    localparam logic [5:0] OFS_FUNCTION_SELECT_EXT = 6'h28;
    localparam logic [5:0] OFS_RMW_LATCH = 6'h2C;
    localparam int BIT_ALL_PORTS_INPUT_ENABLE = 0;
    localparam int BIT_BOOT_COMM_INPUT_ENABLE = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_ENABLE = 2'h0;
    localparam logic [7:0] EXT_FUNCTION_PINS = 8'hFF;
    localparam logic [7:0] BOOT_COMM_PINS = 8'h03;
    typedef enum logic [1:0] {
        LEVEL_CMOS_A = 2'b00,
        LEVEL_AUTOMOTIVE = 2'b01,
        LEVEL_TTL = 2'b10,
        LEVEL_CMOS_B = 2'b11
    } input_level_type;
endpackage

// ### gpio_port_bank.sv
// GPIO port bank with eight pins and a classic Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_bank
    import gpio_port_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [gpio_port_pkg::ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic stop_high_impedance_state,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_i,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_o,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_oe,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] res1_out,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] res1_oe,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] res2_out,
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] res2_oe,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_sampled,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] pull_up_on,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] pull_down_on,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] input_buffer_on,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] drive_reduced,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] level_sel,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] level_sel_ext
);
    import gpio_port_pkg::*;

    logic [1:0] enable_ff, nxt_enable;
    logic [7:0] output_latch_ff, nxt_output_latch;
    logic [7:0] pin_direction_ff, nxt_pin_direction;
    logic [7:0] input_level_select_ff, nxt_input_level_select;
    logic [7:0] input_level_select_ext_ff, nxt_input_level_select_ext;
    logic [7:0] output_drive_select_ff, nxt_output_drive_select;
    logic [7:0] pull_enable_ff, nxt_pull_enable;
    logic [7:0] pull_select_ff, nxt_pull_select;
    logic [7:0] function_select_ff, nxt_function_select;
    logic [7:0] function_select_ext_ff, nxt_function_select_ext;
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] sync3_ff;
    logic [7:0] pin_state_ff;
    logic [7:0] nxt_pin_state;
    logic [31:0] dat_ff, nxt_dat;
    logic ack_ff, nxt_ack;
    logic err_ff, nxt_err;
    logic req;
    logic wr_lane0;
    logic hit;
    logic [7:0] wbyte;
    logic [7:0] gated_in;
    logic [7:0] latch_view;
    logic [7:0] latch_driven;

    // Both enable bits must be set for a boot communication pin to listen.
    function automatic logic [7:0] input_gate(input logic [1:0] en);
        logic [7:0] g;
        g = 8'h00;
        if (en[BIT_ALL_PORTS_INPUT_ENABLE]) begin
            g = 8'hFF;
        end
        if (!en[BIT_BOOT_COMM_INPUT_ENABLE]) begin
            g = g & ~BOOT_COMM_PINS;
        end
        return g;
    endfunction

    function automatic logic is_reg(input logic [5:0] a, input logic [5:0] ofs);
        return a == ofs;
    endfunction

    // A request is taken once; the answer flop blocks it only for the cycle in which the answer is out, so a held strobe is taken again.
    assign req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
    // Only lane zero carries register data; the upper lanes are ignored.
    assign wbyte = wb_dat_i[7:0];
    assign gated_in = input_gate(enable_ff) & ~{8{stop_high_impedance_state}};

    // Pins pass three flip-flops; a change is taken once stages two and three agree.
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_ff <= RST_BYTE;
            sync2_ff <= RST_BYTE;
            sync3_ff <= RST_BYTE;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // The held level only moves once two stages agree, so one unsettled sample cannot leak.
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_state_ff <= RST_BYTE;
        end else begin
            pin_state_ff <= nxt_pin_state;
        end
    end

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            nxt_pin_state[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : pin_state_ff[i];
        end
    end

    // Plain reads of the latch show the sampled pin for GPIO inputs.
    assign latch_driven = pin_direction_ff | function_select_ff;
    assign latch_view = (latch_driven & output_latch_ff) | (~latch_driven & pin_sampled);

    // Register decode: read data for the addressed register and the write update.
    always_comb begin
        nxt_enable = enable_ff;
        nxt_output_latch = output_latch_ff;
        nxt_pin_direction = pin_direction_ff;
        nxt_input_level_select = input_level_select_ff;
        nxt_input_level_select_ext = input_level_select_ext_ff;
        nxt_output_drive_select = output_drive_select_ff;
        nxt_pull_enable = pull_enable_ff;
        nxt_pull_select = pull_select_ff;
        nxt_function_select = function_select_ff;
        nxt_function_select_ext = function_select_ext_ff;
        nxt_dat = 32'h0000_0000;
        hit = 1'b1;

        if (is_reg(wb_adr_i, OFS_GLOBAL_INPUT_ENABLE)) begin
            nxt_dat = {30'h0000_0000, enable_ff};
            if (wr_lane0) begin
                nxt_enable = wbyte[1:0];
            end
        end else if (is_reg(wb_adr_i, OFS_OUTPUT_LATCH)) begin
            nxt_dat = {24'h00_0000, latch_view};
            if (wr_lane0) begin
                nxt_output_latch = wbyte;
            end
        end else if (is_reg(wb_adr_i, OFS_RMW_LATCH)) begin
            // The alias serves read-modify-write sequences, which must see the stored latch.
            nxt_dat = {24'h00_0000, output_latch_ff};
            if (wr_lane0) begin
                nxt_output_latch = wbyte;
            end
        end else if (is_reg(wb_adr_i, OFS_PIN_DIRECTION)) begin
            nxt_dat = {24'h00_0000, pin_direction_ff};
            if (wr_lane0) begin
                nxt_pin_direction = wbyte;
            end
        end else if (is_reg(wb_adr_i, OFS_PIN_DIRECT_READ)) begin
            // Direct reads see the pin whatever its direction.
            nxt_dat = {24'h00_0000, pin_sampled};
        end else if (is_reg(wb_adr_i, OFS_INPUT_LEVEL_SELECT)) begin
            nxt_dat = {24'h00_0000, input_level_select_ff};
            if (wr_lane0) begin
                nxt_input_level_select = wbyte;
            end
        end else if (is_reg(wb_adr_i, OFS_INPUT_LEVEL_SELECT_EXT)) begin
            nxt_dat = {24'h00_0000, input_level_select_ext_ff};
            if (wr_lane0) begin
                nxt_input_level_select_ext = wbyte;
            end
        end else if (is_reg(wb_adr_i, OFS_OUTPUT_DRIVE_SELECT)) begin
            nxt_dat = {24'h00_0000, output_drive_select_ff};
            if (wr_lane0) begin
                nxt_output_drive_select = wbyte;
            end
        end else if (is_reg(wb_adr_i, OFS_PULL_ENABLE)) begin
            nxt_dat = {24'h00_0000, pull_enable_ff};
            if (wr_lane0) begin
                nxt_pull_enable = wbyte;
            end
        end else if (is_reg(wb_adr_i, OFS_PULL_SELECT)) begin
            nxt_dat = {24'h00_0000, pull_select_ff};
            if (wr_lane0) begin
                // A pin whose pull is enabled keeps its select, so the pull never flips while on.
                nxt_pull_select = (pull_enable_ff & pull_select_ff) | (~pull_enable_ff & wbyte);
            end
        end else if (is_reg(wb_adr_i, OFS_FUNCTION_SELECT)) begin
            nxt_dat = {24'h00_0000, function_select_ff};
            if (wr_lane0) begin
                nxt_function_select = wbyte;
            end
        end else if (is_reg(wb_adr_i, OFS_FUNCTION_SELECT_EXT)) begin
            nxt_dat = {24'h00_0000, function_select_ext_ff};
            if (wr_lane0) begin
                // Only pins that have an extended function keep the bit.
                nxt_function_select_ext = wbyte & EXT_FUNCTION_PINS;
            end
        end else begin
            hit = 1'b0;
        end
        // Unmapped addresses answer with an error and change nothing.
        nxt_ack = req && hit;
        nxt_err = req && !hit;
        if (!req || !hit || wb_we_i) begin
            nxt_dat = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            enable_ff <= RST_ENABLE;
            output_latch_ff <= RST_BYTE;
            pin_direction_ff <= RST_BYTE;
            input_level_select_ff <= RST_BYTE;
            input_level_select_ext_ff <= RST_BYTE;
            output_drive_select_ff <= RST_BYTE;
            pull_enable_ff <= RST_BYTE;
            pull_select_ff <= RST_BYTE;
            function_select_ff <= RST_BYTE;
            function_select_ext_ff <= RST_BYTE;
        end else begin
            enable_ff <= nxt_enable;
            output_latch_ff <= nxt_output_latch;
            pin_direction_ff <= nxt_pin_direction;
            input_level_select_ff <= nxt_input_level_select;
            input_level_select_ext_ff <= nxt_input_level_select_ext;
            output_drive_select_ff <= nxt_output_drive_select;
            pull_enable_ff <= nxt_pull_enable;
            pull_select_ff <= nxt_pull_select;
            function_select_ff <= nxt_function_select;
            function_select_ext_ff <= nxt_function_select_ext;
        end
    end

    // The answer drops on its own next cycle, so a held strobe is answered again every second cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            dat_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            dat_ff <= nxt_dat;
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
        end
    end

    // Pad controls follow the registers directly, with no extra delay.
    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign pin_sampled = pin_state_ff & gated_in;
    assign input_buffer_on = gated_in;
    assign drive_reduced = output_drive_select_ff;
    assign level_sel = input_level_select_ff;
    assign level_sel_ext = input_level_select_ext_ff;

    // One slice per pin; bit position matches pin number.
    generate
        for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
            logic res_ctl;
            logic res_val;
            logic is_out;
            logic drive_en;
            logic drive_val;
            logic pull_allowed;

            // A resource that claims the pin drives it whatever the direction bit says.
            assign res_ctl = function_select_ff[p] &&
                             (function_select_ext_ff[p] ? res2_oe[p] : res1_oe[p]);
            assign res_val = function_select_ext_ff[p] ? res2_out[p] : res1_out[p];
            assign is_out = pin_direction_ff[p] || res_ctl;
            assign drive_en = is_out && !stop_high_impedance_state;
            assign drive_val = res_ctl ? res_val : output_latch_ff[p];
            assign pin_oe[p] = drive_en;
            assign pin_o[p] = drive_en && drive_val;

            // Pulls only act on a listening pin; the pull-up also yields to the stop state.
            assign pull_allowed = pull_enable_ff[p] && !is_out;
            assign pull_up_on[p] = pull_allowed && pull_select_ff[p] && !stop_high_impedance_state;
            assign pull_down_on[p] = pull_allowed && !pull_select_ff[p];
        end
    endgenerate
endmodule
`default_nettype wire

// ### gpio_port_bank_properties.sv
// Concurrent checks on the ports of the GPIO port bank.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_bank_properties
    import gpio_port_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic stop_high_impedance_state,
    input wire logic [7:0] pin_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_sampled,
    input wire logic [7:0] pull_up_on,
    input wire logic [7:0] pull_down_on,
    input wire logic [7:0] input_buffer_on,
    input wire logic [7:0] drive_reduced,
    input wire logic [7:0] level_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> (wb_ack_o != wb_err_o) ##1 !(wb_ack_o || wb_err_o); endproperty
    a_answer: assert property (p_answer) else $error("bus answer late or held");
    property p_stop; stop_high_impedance_state |-> pin_oe == 8'h00 && pull_up_on == 8'h00 && input_buffer_on == 8'h00; endproperty
    a_stop: assert property (p_stop) else $error("pin active in stop state");
    property p_pull_excl; (pull_up_on & pull_down_on) == 8'h00; endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
    property p_pull_swap; ($past(pull_up_on) & pull_down_on) == 8'h00 && ($past(pull_down_on) & pull_up_on) == 8'h00; endproperty
    a_pull_swap: assert property (p_pull_swap) else $error("pull flipped while enabled");
    property p_gate; (input_buffer_on == 8'h00) [*4] |-> pin_sampled == 8'h00; endproperty
    a_gate: assert property (p_gate) else $error("sample seen with input off");
    property p_sync; ($stable(pin_i) && $stable(input_buffer_on)) [*6] |-> pin_sampled == (pin_i & input_buffer_on); endproperty
    a_sync: assert property (p_sync) else $error("sample does not settle");
    property p_drive_low; (pin_o & ~pin_oe) == 8'h00; endproperty
    a_drive_low: assert property (p_drive_low) else $error("pin value without enable");
    property p_drv; $changed(drive_reduced) |-> wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == OFS_OUTPUT_DRIVE_SELECT; endproperty
    a_drv: assert property (p_drv) else $error("drive setting changed unasked");
    property p_lvl; $changed(level_sel) |-> wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == OFS_INPUT_LEVEL_SELECT; endproperty
    a_lvl: assert property (p_lvl) else $error("level setting changed unasked");
endmodule
bind gpio_port_bank gpio_port_bank_properties u_props (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_ack_o, .wb_err_o, .stop_high_impedance_state, .pin_i, .pin_o, .pin_oe, .pin_sampled, .pull_up_on,
    .pull_down_on, .input_buffer_on, .drive_reduced, .level_sel);
`default_nettype wire

// ### pin_board_model.sv
// Board model of the eight port pins with an external driver.
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
    input wire logic clk,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_on,
    input wire logic [7:0] pull_down_on,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_i
);
    logic [7:0] last_ff;
    // A pin nobody drives or pulls shows the inverse of its last level, so it never looks settled.
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_up_on | (~pull_down_on & ~last_ff)));
    always_ff @(posedge clk) begin
        last_ff <= pin_i;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the GPIO port bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gpio_port_pkg::*;
    logic clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, stop_high_impedance_state = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, wb_err_o, e;
    logic [7:0] ext_en = 8'hFF, ext_val = 8'h00, res1_out = 8'h00, res1_oe = 8'h00, res2_out = 8'h00, res2_oe = 8'h00;
    logic [7:0] pin_i, pin_o, pin_oe, pin_sampled, pull_up_on, pull_down_on, input_buffer_on, drive_reduced;
    logic [7:0] level_sel, level_sel_ext, en, dir, lat, v;
    integer seed = 32'hB1B14ED7, num_errors = 0, tests_run = 0, cycles = 0;
    gpio_port_bank u_dut (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .wb_err_o, .stop_high_impedance_state, .pin_i, .pin_o, .pin_oe, .res1_out, .res1_oe, .res2_out,
        .res2_oe, .pin_sampled, .pull_up_on, .pull_down_on, .input_buffer_on, .drive_reduced, .level_sel, .level_sel_ext);
    pin_board_model u_board (.clk, .pin_o, .pin_oe, .pull_up_on, .pull_down_on, .ext_en, .ext_val, .pin_i);
    always #4 clk = ~clk;
    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    function automatic logic [7:0] gate(input logic [7:0] g);
        return {8{g[0]}} & (~BOOT_COMM_PINS | {8{g[1]}});
    endfunction
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 12; a++) begin
            xfer(1'b0, 6'(a * 4), 8'h00);
            chk(rd, 32'h0);
        end
        xfer(1'b0, 6'h30, 8'h00);
        chk({31'h0, e}, 32'h1);
        for (int i = 0; i < 40; i++) begin
            en = 8'($random(seed)) & 8'h03;
            dir = 8'($random(seed));
            lat = 8'($random(seed));
            v = 8'($random(seed));
            ext_val <= v;
            ext_en <= ~dir;
            xfer(1'b1, OFS_GLOBAL_INPUT_ENABLE, en);
            xfer(1'b1, OFS_PIN_DIRECTION, dir);
            xfer(1'b1, OFS_OUTPUT_LATCH, lat);
            repeat (6) @(posedge clk);
            chk(pin_oe, dir);
            chk(pin_o, lat & dir);
            chk(pin_sampled, ((dir & lat) | (~dir & v)) & gate(en));
            chk(input_buffer_on, gate(en));
            xfer(1'b0, OFS_OUTPUT_LATCH, 8'h00);
            chk(rd, (dir & lat) | (~dir & v & gate(en)));
            xfer(1'b0, OFS_PIN_DIRECT_READ, 8'h00);
            chk(rd, ((dir & lat) | (~dir & v)) & gate(en));
            xfer(1'b0, OFS_RMW_LATCH, 8'h00);
            chk(rd, lat);
            xfer(1'b0, OFS_GLOBAL_INPUT_ENABLE, 8'h00);
            chk(rd, en);
            xfer(1'b1, OFS_OUTPUT_DRIVE_SELECT, lat);
            chk(drive_reduced, lat);
            xfer(1'b1, OFS_INPUT_LEVEL_SELECT, dir);
            xfer(1'b1, OFS_INPUT_LEVEL_SELECT_EXT, v);
            chk({level_sel, level_sel_ext}, {dir, v});
        end
        ext_en <= 8'h00;
        xfer(1'b1, OFS_GLOBAL_INPUT_ENABLE, 8'h03);
        xfer(1'b1, OFS_PULL_ENABLE, 8'hFF);
        chk({pull_up_on, pull_down_on}, {8'h00, ~dir});
        xfer(1'b1, OFS_PULL_SELECT, 8'hFF);
        chk({pull_up_on, pull_down_on}, {8'h00, ~dir});
        repeat (6) @(posedge clk);
        chk(pin_sampled, dir & lat);
        xfer(1'b1, OFS_PULL_ENABLE, 8'h00);
        xfer(1'b1, OFS_PULL_SELECT, 8'hFF);
        xfer(1'b1, OFS_PULL_ENABLE, 8'hFF);
        chk({pull_up_on, pull_down_on}, {~dir, 8'h00});
        res1_out <= 8'($random(seed));
        res2_out <= 8'($random(seed));
        res1_oe <= 8'hFF;
        res2_oe <= 8'hFF;
        xfer(1'b1, OFS_FUNCTION_SELECT, 8'hFF);
        xfer(1'b1, OFS_FUNCTION_SELECT_EXT, 8'h0F);
        chk({pin_oe, pin_o}, {8'hFF, (res2_out & 8'h0F) | (res1_out & 8'hF0)});
        stop_high_impedance_state <= 1'b1;
        repeat (2) @(posedge clk);
        chk({pin_oe, pull_up_on, input_buffer_on}, 24'h0);
        complete_run();
    end
endmodule
`default_nettype wire
